// ### src/asbs_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "asbs_map.vh"
module asbs_ctrl (
    // clock and reset
    input wire sys_clk_in,
    input wire sys_rst_in,
    // user request port
    input wire req_valid_in,
    input wire req_write_in,
    input wire [`ASBS_ADDR_W-1:0] req_addr_in,
    input wire [`ASBS_LANES-1:0] req_lanes_in,
    input wire [`ASBS_DATA_W-1:0] req_wdata_in,
    output wire req_ready_out,
    output reg rsp_valid_out,
    output reg [`ASBS_DATA_W-1:0] rsp_rdata_out,
    // power management
    input wire retention_req_in,
    output reg retention_ok_out,
    // memory pins
    output reg [`ASBS_ADDR_W-1:0] word_address_out,
    output reg low_lane_select_n_out,
    output reg mid_lane_select_n_out,
    output reg high_lane_select_n_out,
    output reg out_enable_n_out,
    output reg write_strobe_n_out,
    input wire [`ASBS_DATA_W-1:0] shared_data_bus_in,
    output reg [`ASBS_DATA_W-1:0] shared_data_bus_out,
    output reg [`ASBS_DATA_W-1:0] shared_data_bus_oe_n_out
);
    // states
    localparam [2:0] ST_PWR = 3'h0; // power-up wait
    localparam [2:0] ST_IDLE = 3'h1; // deselected standby
    localparam [2:0] ST_RD = 3'h2; // read, waiting for data
    localparam [2:0] ST_RDCAP = 3'h3; // capture read data
    localparam [2:0] ST_WR = 3'h4; // write strobe low
    localparam [2:0] ST_WREND = 3'h5; // write ended, strobe high, data and selects held
    localparam [2:0] ST_RET = 3'h6; // retention, all deselected
    localparam [2:0] ST_REC = 3'h7; // recovery wait
    localparam [31:0] POWER_W = `ASBS_POWER_CYC; // power-up wait, full width
    localparam [31:0] RC_W = `ASBS_RC_CYC; // recovery wait, full width
    localparam [31:0] WR_W = `ASBS_WR_CYC; // strobe low time, full width
    localparam [15:0] POWER_CNT = POWER_W[15:0];
    localparam [15:0] RC_CNT = (RC_W == 32'h00000000) ? 16'h0001 : RC_W[15:0];
    localparam [15:0] WR_CNT = (WR_W == 32'h00000000) ? 16'h0001 : WR_W[15:0];
    reg [2:0] state_q; // current state
    reg [2:0] state_d; // next state
    reg [15:0] wcnt_q; // cycles left in write strobe
    reg load_d; // timer load pulse
    reg [15:0] load_cnt_d; // timer load value
    reg [`ASBS_DATA_W-1:0] rd_s1_q; // bus sync stage 1
    reg [`ASBS_DATA_W-1:0] rd_s2_q; // bus sync stage 2
    reg started_q; // timer loaded after reset
    reg rsp_pend_q; // read data sits in sync stage 2 this cycle
    wire tmr_done; // wait elapsed
    wire [`ASBS_LANES-1:0] sel_n; // active-low lane selects
    // wait timer for power-up and recovery
    asbs_wait_timer u_tmr (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .load_in(load_d),
        .count_in(load_cnt_d),
        .done_out(tmr_done)
    );
    assign sel_n = {high_lane_select_n_out, mid_lane_select_n_out, low_lane_select_n_out};
    // accept only in idle, never during retention or waits
    assign req_ready_out = (state_q == ST_IDLE) && !retention_req_in;
    // timer load decisions
    always @* begin
        load_d = 1'b0;
        load_cnt_d = POWER_CNT;
        if (!started_q) begin
            load_d = 1'b1;
        end else if (state_q == ST_RET && !retention_req_in) begin
            load_d = 1'b1;
            load_cnt_d = RC_CNT;
        end
    end
    // next state
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_PWR: begin
                if (started_q && tmr_done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (retention_req_in) begin
                    state_d = ST_RET;
                end else if (req_valid_in) begin
                    state_d = req_write_in ? ST_WR : ST_RD;
                end
            end
            ST_RD: state_d = ST_RDCAP;
            ST_RDCAP: state_d = ST_IDLE;
            ST_WR: begin
                if (wcnt_q <= 16'h0001) begin
                    state_d = ST_WREND;
                end
            end
            ST_WREND: state_d = ST_IDLE;
            ST_RET: begin
                if (!retention_req_in) begin
                    state_d = ST_REC;
                end
            end
            ST_REC: begin
                if (tmr_done) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_PWR;
        endcase
    end
    // state, counters and read sync
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= ST_PWR;
            started_q <= 1'b0;
            rsp_pend_q <= 1'b0;
            wcnt_q <= 16'h0000;
            rd_s1_q <= {`ASBS_DATA_W{1'b0}};
            rd_s2_q <= {`ASBS_DATA_W{1'b0}};
        end else begin
            state_q <= state_d;
            started_q <= 1'b1;
            rsp_pend_q <= (state_q == ST_RDCAP); // sync needs a cycle past capture
            rd_s1_q <= shared_data_bus_in; // two-stage pin sync
            rd_s2_q <= rd_s1_q;
            if (state_q == ST_IDLE && state_d == ST_WR) begin
                wcnt_q <= WR_CNT;
            end else if (wcnt_q != 16'h0000) begin
                wcnt_q <= wcnt_q - 16'h0001;
            end
        end
    end
    // pin drive and responses
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            word_address_out <= {`ASBS_ADDR_W{1'b0}};
            low_lane_select_n_out <= 1'b1;
            mid_lane_select_n_out <= 1'b1;
            high_lane_select_n_out <= 1'b1;
            out_enable_n_out <= 1'b1;
            write_strobe_n_out <= 1'b1;
            shared_data_bus_out <= {`ASBS_DATA_W{1'b0}};
            shared_data_bus_oe_n_out <= {`ASBS_DATA_W{1'b1}};
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= {`ASBS_DATA_W{1'b0}};
            retention_ok_out <= 1'b0;
        end else begin
            rsp_valid_out <= rsp_pend_q; // one-cycle pulse after capture
            if (rsp_pend_q) begin
                // stage 2 now holds the pins as seen while the read was open
                rsp_rdata_out <= rd_s2_q;
            end
            // ok only once every lane select reads back high
            retention_ok_out <= (state_d == ST_RET) && (state_q == ST_RET) && (&sel_n);
            case (state_d)
                ST_RD: begin
                    if (state_q == ST_IDLE) begin
                        // read: address and lanes together, bus released
                        word_address_out <= req_addr_in;
                        {high_lane_select_n_out, mid_lane_select_n_out,
                            low_lane_select_n_out} <= ~req_lanes_in;
                        out_enable_n_out <= 1'b0;
                        write_strobe_n_out <= 1'b1;
                        shared_data_bus_oe_n_out <= {`ASBS_DATA_W{1'b1}};
                    end
                end
                ST_RDCAP: begin
                    // hold selects one more cycle while sync settles
                end
                ST_WR: begin
                    if (state_q == ST_IDLE) begin
                        // write: output enable high, strobe low, data driven
                        word_address_out <= req_addr_in;
                        {high_lane_select_n_out, mid_lane_select_n_out,
                            low_lane_select_n_out} <= ~req_lanes_in;
                        out_enable_n_out <= 1'b1;
                        write_strobe_n_out <= 1'b0;
                        shared_data_bus_out <= req_wdata_in;
                        shared_data_bus_oe_n_out <= {`ASBS_DATA_W{1'b0}};
                    end
                end
                ST_WREND: begin
                    // strobe rises first, selects and data held to satisfy hold
                    write_strobe_n_out <= 1'b1;
                end
                default: begin
                    // idle, retention, waits: everything deselected, bus floated
                    low_lane_select_n_out <= 1'b1;
                    mid_lane_select_n_out <= 1'b1;
                    high_lane_select_n_out <= 1'b1;
                    out_enable_n_out <= 1'b1;
                    write_strobe_n_out <= 1'b1;
                    shared_data_bus_oe_n_out <= {`ASBS_DATA_W{1'b1}};
                end
            endcase
        end
    end
endmodule // asbs_ctrl
`default_nettype wire

// ### src/asbs_map.vh
`ifndef ASBS_MAP_VH
`define ASBS_MAP_VH
// geometry
`define ASBS_ADDR_W 19
`define ASBS_DATA_W 24
`define ASBS_LANES 3
// clock period in ns (10 MHz)
`define ASBS_CLK_NS 100
// power-up wait before first access, microseconds
`define ASBS_T_POWER_US 100
// read cycle time, ns (recovery after retention)
`define ASBS_T_RC_NS 10
// output turn-off plus data setup, ps (write strobe low minimum)
`define ASBS_T_HZWE_PS 5000
`define ASBS_T_SD_PS 5500
// derived cycle counts (least times round up, at least one)
`define ASBS_POWER_CYC ((`ASBS_T_POWER_US * 1000 + `ASBS_CLK_NS - 1) / `ASBS_CLK_NS)
`define ASBS_RC_CYC (((`ASBS_T_RC_NS + `ASBS_CLK_NS - 1) / `ASBS_CLK_NS) + 0)
`define ASBS_WR_CYC ((`ASBS_T_HZWE_PS + `ASBS_T_SD_PS + `ASBS_CLK_NS * 1000 - 1) / (`ASBS_CLK_NS * 1000))
`endif

// ### src/asbs_wait_timer.v
`timescale 1ns/1ps
`default_nettype none
// down counter: load a count, done stays high while idle at zero
module asbs_wait_timer (
    // clock and reset
    input wire sys_clk_in,
    input wire sys_rst_in,
    // control
    input wire load_in,
    input wire [15:0] count_in,
    // status
    output wire done_out
);
    reg [15:0] cnt_q; // remaining cycles
    // count down after load
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_q <= 16'h0000;
        end else if (load_in) begin
            cnt_q <= count_in;
        end else if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end
    assign done_out = (cnt_q == 16'h0000) && !load_in;
endmodule // asbs_wait_timer
`default_nettype wire

// ### verif/asbs_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module asbs_ctrl_monitor (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // controller status
    input wire logic rsp_valid_out,
    input wire logic retention_ok_out,
    // memory pins
    input wire logic low_lane_select_n_out,
    input wire logic mid_lane_select_n_out,
    input wire logic high_lane_select_n_out,
    input wire logic out_enable_n_out,
    input wire logic write_strobe_n_out,
    input wire logic [23:0] shared_data_bus_out,
    input wire logic [23:0] shared_data_bus_oe_n_out
);
    // all three selects high
    wire all_off = low_lane_select_n_out & mid_lane_select_n_out & high_lane_select_n_out;
    reg [10:0] up_q; // edges since reset, saturating
    // counts the power-up wait
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) up_q <= 11'h000;
        else if (up_q != 11'h7ff) up_q <= up_q + 11'h001;
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    power_wait_a: assert property (!all_off |-> up_q >= 11'h3e8)
        else $error("select before power-up wait");
    wr_start_a: assert property ($fell(write_strobe_n_out) |-> !all_off)
        else $error("strobe without select");
    wr_hold_a: assert property ($rose(write_strobe_n_out) |-> $stable(shared_data_bus_out) && !all_off)
        else $error("write data moved at write end");
    no_clash_a: assert property (shared_data_bus_oe_n_out != 24'hffffff |-> out_enable_n_out)
        else $error("bus driven while memory may drive");
    wr_pulse_a: assert property (!write_strobe_n_out |-> shared_data_bus_oe_n_out != 24'hffffff ##1 write_strobe_n_out)
        else $error("strobe pulse wrong");
    ret_idle_a: assert property (retention_ok_out |-> all_off)
        else $error("selected during retention");
    ret_wake_a: assert property ($fell(retention_ok_out) |-> all_off)
        else $error("access without recovery");
    rd_resp_a: assert property ($rose(rsp_valid_out) |-> !$past(out_enable_n_out, 2) && $past(write_strobe_n_out, 2))
        else $error("response without read");
endmodule // asbs_ctrl_monitor
bind asbs_ctrl asbs_ctrl_monitor u_mon (.sys_clk_in, .sys_rst_in, .rsp_valid_out, .retention_ok_out,
    .low_lane_select_n_out, .mid_lane_select_n_out, .high_lane_select_n_out, .out_enable_n_out,
    .write_strobe_n_out, .shared_data_bus_out, .shared_data_bus_oe_n_out);
`default_nettype wire

// ### verif/asbs_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module asbs_mem_model #(parameter integer RD_DLY_NS = 10) (
    // pins from the controller
    input wire logic [18:0] word_address_in,
    input wire logic [2:0] select_n_in,
    input wire logic out_enable_n_in,
    input wire logic write_strobe_n_in,
    input wire logic [23:0] bus_level_in,
    // data drive towards the bus
    output logic [23:0] drive_data_out,
    output logic [23:0] drive_en_out
);
    logic [23:0] mem [0:524287]; // whole word array
    logic [2:0] wl; // lanes of the open write
    logic [23:0] wd, wm;
    logic [18:0] wa;
    wire [2:0] sel = ~select_n_in; // any low select is active
    wire win = !write_strobe_n_in && (sel != 3'h0); // write window
    wire rd = write_strobe_n_in && !out_enable_n_in; // oe high or writing floats
    // track data while the window is open
    always @* begin
        if (win) begin
            wl = sel; // only selected lanes taken
            wd = bus_level_in;
            wa = word_address_in;
        end
    end
    // commit at the edge that ends the window
    always @(negedge win) begin
        wm = {{8{wl[2]}}, {8{wl[1]}}, {8{wl[0]}}};
        mem[wa] = (mem[wa] & ~wm) | (wd & wm);
    end
    // deselected lanes float at once, wake has no delay
    assign drive_en_out = {{8{rd & sel[2]}}, {8{rd & sel[1]}}, {8{rd & sel[0]}}};
    assign #(RD_DLY_NS) drive_data_out = mem[word_address_in]; // slow access
endmodule // asbs_mem_model
`default_nettype wire

// ### verif/async_sram_byte_select_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module async_sram_byte_select_port_tb;
    logic sys_clk_in = 1'b0, sys_rst_in = 1'b1, req_valid_in = 1'b0, req_write_in = 1'b0;
    logic retention_req_in = 1'b0;
    logic [18:0] req_addr_in = 19'h00000;
    logic [2:0] req_lanes_in = 3'h0;
    logic [23:0] req_wdata_in = 24'h000000, float_q = 24'h5a3c96; // idle bus flips each cycle
    wire req_ready_out, rsp_valid_out, retention_ok_out, out_enable_n_out, write_strobe_n_out;
    wire low_lane_select_n_out, mid_lane_select_n_out, high_lane_select_n_out;
    wire [23:0] rsp_rdata_out, shared_data_bus_out, shared_data_bus_oe_n_out, mem_d, mem_en;
    wire [23:0] shared_data_bus_in;
    wire [18:0] word_address_out;
    wire [2:0] sel_n = {high_lane_select_n_out, mid_lane_select_n_out, low_lane_select_n_out};
    int mismatches = 0, total_checks = 0, cycles = 0, i;
    logic [23:0] shadow [0:7]; // expected words
    // resolve the shared bus from both drivers
    assign shared_data_bus_in = (~shared_data_bus_oe_n_out & shared_data_bus_out)
        | (shared_data_bus_oe_n_out & mem_en & mem_d) | (shared_data_bus_oe_n_out & ~mem_en & float_q);
    always #50 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) float_q <= ~float_q;
    asbs_ctrl DUT (.sys_clk_in, .sys_rst_in, .req_valid_in, .req_write_in, .req_addr_in,
        .req_lanes_in, .req_wdata_in, .req_ready_out, .rsp_valid_out, .rsp_rdata_out,
        .retention_req_in, .retention_ok_out, .word_address_out, .low_lane_select_n_out,
        .mid_lane_select_n_out, .high_lane_select_n_out, .out_enable_n_out, .write_strobe_n_out,
        .shared_data_bus_in, .shared_data_bus_out, .shared_data_bus_oe_n_out);
    asbs_mem_model #(.RD_DLY_NS(45)) u_mem (.word_address_in(word_address_out), .select_n_in(sel_n),
        .out_enable_n_in(out_enable_n_out), .write_strobe_n_in(write_strobe_n_out),
        .bus_level_in(shared_data_bus_in), .drive_data_out(mem_d), .drive_en_out(mem_en));
    // cut a hang short
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            complete_run();
        end
    end
    function automatic [23:0] lane_mask(input [2:0] l);
        lane_mask = {{8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
    endfunction
    task automatic check(input [23:0] seen, input [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // one request; reads compare the selected lanes only
    task automatic op(input w, input [2:0] k, input [2:0] l, input [23:0] d);
        int n;
        @(posedge sys_clk_in);
        #1;
        {req_write_in, req_addr_in, req_lanes_in, req_wdata_in} = {w, k, 13'h0a5b, k, l, d};
        req_valid_in = 1'b1;
        for (n = 0; n < 1100 && req_ready_out !== 1'b1; n++) @(posedge sys_clk_in) #1;
        @(posedge sys_clk_in) #1;
        req_valid_in = 1'b0;
        if (w) shadow[k] = (shadow[k] & ~lane_mask(l)) | (d & lane_mask(l));
        else begin
            for (n = 0; n < 6 && rsp_valid_out !== 1'b1; n++) @(posedge sys_clk_in) #1;
            check(24'(rsp_valid_out), 24'h000001);
            check(rsp_rdata_out & lane_mask(l), shadow[k] & lane_mask(l));
        end
    endtask
    initial begin
        void'($urandom(32'h2d871db8));
        repeat (3) @(posedge sys_clk_in);
        #1 sys_rst_in = 1'b0;
        for (i = 0; i < 8; i++) op(1'b1, 3'(i), 3'h7, 24'($urandom));
        for (i = 1; i < 8; i++) begin
            op(1'b1, 3'(i), 3'(i), 24'($urandom));
            op(1'b0, 3'(i), 3'(8 - i), 24'h000000);
        end
        $display("lane codes done");
        repeat (60) op(1'($urandom), 3'($urandom), 3'($urandom % 7 + 1), 24'($urandom));
        $display("random traffic done");
        @(posedge sys_clk_in) #1 retention_req_in = 1'b1;
        repeat (4) @(posedge sys_clk_in);
        #1;
        check(24'({retention_ok_out, sel_n, req_ready_out}), 24'h00001e);
        retention_req_in = 1'b0;
        for (i = 0; i < 8; i++) op(1'b0, 3'(i), 3'h7, 24'h000000);
        $display("retention done");
        complete_run();
    end
endmodule // async_sram_byte_select_port_tb
`default_nettype wire
